// ---- common/qa_watchdog_window_config_map.vh ----
// Constants for the question-and-answer watchdog configuration block
`ifndef QA_WATCHDOG_WINDOW_CONFIG_MAP_VH
`define QA_WATCHDOG_WINDOW_CONFIG_MAP_VH

// Controller register select codes
`define SEL_WINDOW_ONE 2'h0
`define SEL_WINDOW_TWO 2'h1
`define SEL_QUESTION 2'h2

// Reset values
`define WINDOW_ONE_RESET 8'hff
`define WINDOW_TWO_RESET 5'h1f
`define ANSWER_SELECT_RESET 2'h0
`define POLY_SELECT_RESET 2'h0
`define SEED_RESET 4'ha

// Field positions inside the question setup register
`define ANSWER_MSB 7
`define ANSWER_LSB 6
`define POLY_MSB 5
`define POLY_LSB 4
`define SEED_MSB 3
`define SEED_LSB 0

// Window step timing
`define STEP_TIME_NS 550000
`define CLK_PERIOD_NS 8

// Checksum generator polynomial and start value
`define CHECKSUM_POLY 8'h07
`define CHECKSUM_INIT 8'hff

// Question register feedback taps, one set per polynomial selection
`define TAPS_POLY0 4'h9
`define TAPS_POLY1 4'hc
`define TAPS_POLY2 4'h3
`define TAPS_POLY3 4'h6

`endif

// ---- verilog/qa_watchdog_window_config.v ----
// Window, question and checksum configuration of the question-and-answer watchdog
//
// Contract
// - Configuration writes accepted only in diagnostic state with lock clear.
// - First window lasts (setting+1) x 0.55 ms; setting resets to all ones.
// - Second window lasts (setting+1) x 0.55 ms; 5-bit setting resets to ones.
// - Seed loads into question register while in RESET state; default 1010b.
// - Answer formation select in bits 7-6, resets to zero.
// - Polynomial select in bits 5-4, resets to zero.
// - Question setup resets on power-on, RESET, self-test, mode change.
// - Both window registers reset on power-on, RESET, mode change.
// - Checksum covers all three registers, compared with expected value.
`timescale 1ns/1ps
`include "qa_watchdog_window_config_map.vh"

module qa_watchdog_window_config #(
  parameter STEP_CYCLES = (`STEP_TIME_NS / `CLK_PERIOD_NS)
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire diagnostic_state_in,
  input wire reset_state_in,
  input wire config_lock_in,
  input wire logic_self_test_done_in,
  input wire watchdog_mode_select_in,
  input wire [1:0] reg_select_in,
  input wire write_strobe_in,
  input wire [7:0] write_data_in,
  input wire read_strobe_in,
  input wire [7:0] expected_settings_checksum_in,
  input wire window_start_in,
  input wire question_advance_in,
  output reg [7:0] read_data_out,
  output reg read_valid_out,
  output reg [7:0] first_window_length_out,
  output reg [4:0] second_window_length_out,
  output reg [1:0] answer_formation_select_out,
  output reg [1:0] question_polynomial_select_out,
  output reg [3:0] question_seed_out,
  output reg [3:0] question_value_out,
  output reg [7:0] settings_checksum_out,
  output reg checksum_mismatch_out,
  output reg first_window_active_out,
  output reg second_window_active_out,
  output reg window_expired_out
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WIN1 = 2'h1;
  localparam [1:0] ST_WIN2 = 2'h2;
  // Step length minus one, cut on purpose to the divider width
  localparam integer STEP_LAST_FULL = STEP_CYCLES - 1;
  localparam [16:0] STEP_LAST = STEP_LAST_FULL[16:0];

  reg mode_prev;
  reg mode_seen;
  reg reset_state_prev;
  reg [1:0] state;
  reg [16:0] step_count;
  reg [7:0] window_count;
  reg [3:0] taps;

  wire mode_change;
  wire reset_entry;
  wire write_ok;
  wire step_tick;
  wire [7:0] next_checksum;

  // Mode change only counts once a previous mode has been sampled
  assign mode_change = mode_seen && (mode_prev != watchdog_mode_select_in);
  assign reset_entry = reset_state_in && !reset_state_prev;
  assign write_ok = write_strobe_in && diagnostic_state_in && !config_lock_in;
  assign step_tick = (step_count == STEP_LAST);

  // Bitwise checksum over window one, window two and question setup
  function [7:0] checksum8;
    input [23:0] data;
    reg [7:0] crc;
    integer i;
    begin
      crc = `CHECKSUM_INIT;
      for (i = 23; i >= 0; i = i - 1) begin
        if (crc[7] ^ data[i]) begin
          crc = {crc[6:0], 1'b0} ^ `CHECKSUM_POLY;
        end else begin
          crc = {crc[6:0], 1'b0};
        end
      end
      checksum8 = crc;
    end
  endfunction

  assign next_checksum = checksum8({first_window_length_out, 3'h0, second_window_length_out,
    answer_formation_select_out, question_polynomial_select_out, question_seed_out});

  // Event history for mode and RESET state edges
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_prev <= 1'b0;
      mode_seen <= 1'b0;
      reset_state_prev <= 1'b0;
    end else begin
      mode_prev <= watchdog_mode_select_in;
      mode_seen <= 1'b1;
      reset_state_prev <= reset_state_in;
    end
  end

  // Window registers; initialisation events beat a same-cycle write
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      first_window_length_out <= `WINDOW_ONE_RESET;
      second_window_length_out <= `WINDOW_TWO_RESET;
    end else if (reset_entry || mode_change) begin
      first_window_length_out <= `WINDOW_ONE_RESET;
      second_window_length_out <= `WINDOW_TWO_RESET;
    end else if (write_ok) begin
      if (reg_select_in == `SEL_WINDOW_ONE) begin
        first_window_length_out <= write_data_in;
      end
      if (reg_select_in == `SEL_WINDOW_TWO) begin
        second_window_length_out <= write_data_in[4:0];
      end
    end
  end

  // Question setup register; self-test also reinitialises it
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      answer_formation_select_out <= `ANSWER_SELECT_RESET;
      question_polynomial_select_out <= `POLY_SELECT_RESET;
      question_seed_out <= `SEED_RESET;
    end else if (reset_entry || mode_change || logic_self_test_done_in) begin
      answer_formation_select_out <= `ANSWER_SELECT_RESET;
      question_polynomial_select_out <= `POLY_SELECT_RESET;
      question_seed_out <= `SEED_RESET;
    end else if (write_ok && reg_select_in == `SEL_QUESTION) begin
      answer_formation_select_out <= write_data_in[`ANSWER_MSB:`ANSWER_LSB];
      question_polynomial_select_out <= write_data_in[`POLY_MSB:`POLY_LSB];
      question_seed_out <= write_data_in[`SEED_MSB:`SEED_LSB];
    end
  end

  // Read port, one cycle after the strobe
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      read_data_out <= 8'h00;
      read_valid_out <= 1'b0;
    end else begin
      read_valid_out <= read_strobe_in;
      if (read_strobe_in) begin
        case (reg_select_in)
          `SEL_WINDOW_ONE: read_data_out <= first_window_length_out;
          `SEL_WINDOW_TWO: read_data_out <= {3'h0, second_window_length_out};
          `SEL_QUESTION: read_data_out <= {answer_formation_select_out,
            question_polynomial_select_out, question_seed_out};
          default: read_data_out <= 8'h00;
        endcase
      end
    end
  end

  // Checksum result and comparison, registered to cut the long xor path
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      settings_checksum_out <= 8'h00;
      checksum_mismatch_out <= 1'b0;
    end else begin
      settings_checksum_out <= next_checksum;
      checksum_mismatch_out <= (next_checksum != expected_settings_checksum_in);
    end
  end

  // Feedback taps chosen by the polynomial selection
  always @* begin
    case (question_polynomial_select_out)
      2'h0: taps = `TAPS_POLY0;
      2'h1: taps = `TAPS_POLY1;
      2'h2: taps = `TAPS_POLY2;
      default: taps = `TAPS_POLY3;
    endcase
  end

  // Question register: held at the seed through the RESET state
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      question_value_out <= `SEED_RESET;
    end else if (reset_state_in) begin
      question_value_out <= question_seed_out;
    end else if (question_advance_in) begin
      question_value_out <= {question_value_out[2:0], ^(question_value_out & taps)};
    end
  end

  // Step divider runs only while a window is open, so each window starts aligned
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      step_count <= 17'h00000;
    end else if (state == ST_IDLE || step_tick) begin
      step_count <= 17'h00000;
    end else begin
      step_count <= step_count + 17'h00001;
    end
  end

  // Window sequencer: first window, then second, then expiry pulse
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ST_IDLE;
      window_count <= 8'h00;
      first_window_active_out <= 1'b0;
      second_window_active_out <= 1'b0;
      window_expired_out <= 1'b0;
    end else begin
      window_expired_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (window_start_in && !reset_state_in) begin
            state <= ST_WIN1;
            window_count <= 8'h00;
            first_window_active_out <= 1'b1;
          end
        end
        ST_WIN1: begin
          if (step_tick) begin
            if (window_count == first_window_length_out) begin
              state <= ST_WIN2;
              window_count <= 8'h00;
              first_window_active_out <= 1'b0;
              second_window_active_out <= 1'b1;
            end else begin
              window_count <= window_count + 8'h01;
            end
          end
        end
        ST_WIN2: begin
          if (step_tick) begin
            if (window_count == {3'h0, second_window_length_out}) begin
              state <= ST_IDLE;
              second_window_active_out <= 1'b0;
              window_expired_out <= 1'b1;
            end else begin
              window_count <= window_count + 8'h01;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          first_window_active_out <= 1'b0;
          second_window_active_out <= 1'b0;
        end
      endcase
      // RESET state aborts any running window
      if (reset_state_in) begin
        state <= ST_IDLE;
        first_window_active_out <= 1'b0;
        second_window_active_out <= 1'b0;
      end
    end
  end

endmodule

// ---- testbench/qa_watchdog_window_config_assertions.sv ----
// Port assertions for the watchdog configuration block
`timescale 1ns/1ps
module qa_watchdog_window_config_checker (
  input wire clk_in,
  input wire rst_b_in,
  input wire diagnostic_state_in,
  input wire reset_state_in,
  input wire config_lock_in,
  input wire logic_self_test_done_in,
  input wire watchdog_mode_select_in,
  input wire [1:0] reg_select_in,
  input wire write_strobe_in,
  input wire [7:0] write_data_in,
  input wire read_strobe_in,
  input wire [7:0] read_data_out,
  input wire read_valid_out,
  input wire [7:0] first_window_length_out,
  input wire [4:0] second_window_length_out,
  input wire [1:0] answer_formation_select_out,
  input wire [3:0] question_seed_out,
  input wire [3:0] question_value_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // No init event pending, since init beats a write
  wire calm = !reset_state_in && !logic_self_test_done_in;
  a_write_taken: assert property (
    write_strobe_in && diagnostic_state_in && !config_lock_in && reg_select_in == 2'h0 && calm
    && $stable(watchdog_mode_select_in) |=> first_window_length_out == $past(write_data_in))
    else $error("window one write lost");
  a_refused_hold: assert property (
    write_strobe_in && !(diagnostic_state_in && !config_lock_in) && calm && $stable(watchdog_mode_select_in)
    |=> $stable(first_window_length_out) && $stable(second_window_length_out) && $stable(question_seed_out))
    else $error("refused write changed settings");
  a_read_timing: assert property (read_valid_out == $past(read_strobe_in))
    else $error("read valid timing wrong");
  a_rsv_zero: assert property (
    read_valid_out && $past(reg_select_in) == 2'h1 |-> read_data_out[7:5] == 3'h0)
    else $error("reserved bits not zero");
  a_reset_entry: assert property ($rose(reset_state_in) |=> first_window_length_out == 8'hff
    && second_window_length_out == 5'h1f && answer_formation_select_out == 2'h0 && question_seed_out == 4'ha)
    else $error("reset state entry did not init");
  a_mode_init: assert property ($changed(watchdog_mode_select_in) |=> first_window_length_out == 8'hff
    && second_window_length_out == 5'h1f && answer_formation_select_out == 2'h0 && question_seed_out == 4'ha)
    else $error("mode change did not init");
  a_selftest_init: assert property (
    logic_self_test_done_in |=> answer_formation_select_out == 2'h0 && question_seed_out == 4'ha)
    else $error("self test did not init");
  a_seed_load: assert property (
    reset_state_in && $past(reset_state_in) |=> question_value_out == $past(question_seed_out))
    else $error("seed not loaded");
endmodule
bind qa_watchdog_window_config qa_watchdog_window_config_checker chk_i (.*);

// ---- testbench/mcu_model.sv ----
// Controller model issuing register reads and writes
`timescale 1ns/1ps
module mcu_model (
  input wire clk_in,
  input wire [7:0] read_data_in,
  input wire read_valid_in,
  output logic [1:0] reg_select_out = 2'h3,
  output logic write_strobe_out = 1'b0,
  output logic [7:0] write_data_out = 8'h00,
  output logic read_strobe_out = 1'b0
);
  // Caller sets state and lock; one strobe cycle per write
  task wr(input logic [1:0] sel, input logic [7:0] d);
    @(posedge clk_in);
    reg_select_out <= sel;
    write_data_out <= d;
    write_strobe_out <= 1'b1;
    @(posedge clk_in);
    write_strobe_out <= 1'b0;
    write_data_out <= ~d; // Stale data is not held
  endtask
  // Missing valid returns unknown so the caller flags it
  task rd(input logic [1:0] sel, output logic [7:0] d);
    @(posedge clk_in);
    reg_select_out <= sel;
    read_strobe_out <= 1'b1;
    @(posedge clk_in);
    read_strobe_out <= 1'b0;
    #1 d = read_valid_in ? read_data_in : 8'hxx;
  endtask
endmodule

// ---- testbench/qa_watchdog_window_config_bench.sv ----
// Self-checking bench for the watchdog configuration block
`timescale 1ns/1ps
`include "qa_watchdog_window_config_map.vh"
module qa_watchdog_window_config_bench;
  localparam int STEP = 4; // Short step keeps window runs brief
  logic clk_in = 1'b0, rst_b_in = 1'b0, diagnostic_state_in = 1'b0, reset_state_in = 1'b0;
  logic config_lock_in = 1'b0, logic_self_test_done_in = 1'b0, watchdog_mode_select_in = 1'b0;
  logic window_start_in = 1'b0, question_advance_in = 1'b0;
  logic [7:0] expected_settings_checksum_in = 8'h00, rdat;
  wire [1:0] reg_select_in, answer_formation_select_out, question_polynomial_select_out;
  wire [7:0] write_data_in, read_data_out, first_window_length_out, settings_checksum_out;
  wire [4:0] second_window_length_out;
  wire [3:0] question_seed_out, question_value_out;
  wire write_strobe_in, read_strobe_in, read_valid_out, checksum_mismatch_out;
  wire first_window_active_out, second_window_active_out, window_expired_out;
  int n_mismatch = 0, checks = 0, n;
  always #4 clk_in = ~clk_in;
  qa_watchdog_window_config #(.STEP_CYCLES(STEP)) dut (.*);
  mcu_model mcu (.clk_in, .read_data_in(read_data_out), .read_valid_in(read_valid_out),
    .reg_select_out(reg_select_in), .write_strobe_out(write_strobe_in), .write_data_out(write_data_in),
    .read_strobe_out(read_strobe_in));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Reference checksum, MSB first
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // Reference question step: shift left, feedback is xor of tapped bits
  function automatic logic [3:0] q_step(input logic [3:0] q, input logic [3:0] t);
    return {q[2:0], ^(q & t)};
  endfunction
  task rd_chk(input logic [1:0] sel, input logic [7:0] exp);
    mcu.rd(sel, rdat);
    chk(rdat, exp);
  endtask
  task t_defaults;
    rd_chk(`SEL_WINDOW_ONE, 8'hff);
    rd_chk(`SEL_WINDOW_TWO, 8'h1f);
    rd_chk(`SEL_QUESTION, 8'h0a);
    rd_chk(2'h3, 8'h00);
    chk({7'h0, checksum_mismatch_out}, {7'h0, crc8(24'hff1f0a) != 8'h00});
  endtask
  // Legal writes, then locked and non-diagnostic ones that must bounce
  task t_writes;
    @(posedge clk_in) diagnostic_state_in <= 1'b1;
    mcu.wr(`SEL_WINDOW_ONE, 8'h02);
    mcu.wr(`SEL_WINDOW_TWO, 8'he1);
    mcu.wr(`SEL_QUESTION, 8'hd5);
    rd_chk(`SEL_WINDOW_TWO, 8'h01);
    rd_chk(`SEL_QUESTION, 8'hd5);
    chk({answer_formation_select_out, question_polynomial_select_out, question_seed_out}, 8'hd5);
    @(posedge clk_in) question_advance_in <= 1'b1;
    @(posedge clk_in) question_advance_in <= 1'b0;
    #1 chk({4'h0, question_value_out}, {4'h0, q_step(`SEED_RESET, `TAPS_POLY1)});
    @(posedge clk_in) config_lock_in <= 1'b1;
    mcu.wr(`SEL_WINDOW_ONE, 8'h77);
    @(posedge clk_in) config_lock_in <= 1'b0;
    diagnostic_state_in <= 1'b0;
    mcu.wr(`SEL_QUESTION, 8'h77);
    rd_chk(`SEL_WINDOW_ONE, 8'h02);
    rd_chk(`SEL_QUESTION, 8'hd5);
    chk(settings_checksum_out, crc8(24'h0201d5));
    @(posedge clk_in) expected_settings_checksum_in <= crc8(24'h0201d5);
    repeat (2) @(posedge clk_in);
    #1 chk({7'h0, checksum_mismatch_out}, 8'h00);
  endtask
  // Window one setting 2, window two setting 1; counting starts at the edge that takes the start
  task t_windows;
    int n1, n2;
    n = 0;
    n1 = 0;
    n2 = 0;
    @(posedge clk_in) window_start_in <= 1'b1;
    do begin
      @(posedge clk_in) window_start_in <= 1'b0;
      #1 n++;
      if (first_window_active_out === 1'b1) n1++;
      if (second_window_active_out === 1'b1) n2++;
    end while (window_expired_out !== 1'b1 && n < 200);
    if (n >= 200) n_mismatch++; // Timed out waiting for expiry
    chk(n1[7:0], 8'(3 * STEP));
    chk(n2[7:0], 8'(2 * STEP));
    chk(n[7:0], 8'(1 + 3 * STEP + 2 * STEP));
  endtask
  task t_inits;
    @(posedge clk_in) logic_self_test_done_in <= 1'b1;
    @(posedge clk_in) logic_self_test_done_in <= 1'b0;
    #1 chk({answer_formation_select_out, question_polynomial_select_out, question_seed_out}, 8'h0a);
    chk(first_window_length_out, 8'h02);
    @(posedge clk_in) reset_state_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 chk({4'h0, question_value_out}, 8'h0a);
    chk({3'h0, second_window_length_out}, 8'h1f);
    @(posedge clk_in) reset_state_in <= 1'b0;
    diagnostic_state_in <= 1'b1;
    mcu.wr(`SEL_WINDOW_ONE, 8'h33);
    mcu.wr(`SEL_QUESTION, 8'h5c);
    #1 chk(first_window_length_out, 8'h33);
    chk({answer_formation_select_out, question_polynomial_select_out, question_seed_out}, 8'h5c);
    @(posedge clk_in) watchdog_mode_select_in <= 1'b1;
    @(posedge clk_in);
    #1 chk(first_window_length_out, 8'hff);
    chk({answer_formation_select_out, question_polynomial_select_out, question_seed_out}, 8'h0a);
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_defaults;
    t_writes;
    t_windows;
    t_inits;
    end_of_test;
  end
endmodule
